//--- can_host_ctrl.sv
// CAN bring-up and flag service host with an AXI4-Lite command port
`timescale 1ns/1ps
`default_nettype none
`include "can_host_map.svh"

module can_host_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [5:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [5:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	output logic dev_req,
	output logic dev_write,
	output logic [11:0] dev_addr,
	output logic [31:0] dev_wdata,
	input wire logic dev_ack,
	input wire logic [31:0] dev_rdata,
	output logic external_time_tick
);

	can_host_pkg::host_t q_r;
	can_host_pkg::host_t q_nxt;
	logic [3:0] widx;
	logic [3:0] ridx;
	logic fd_on;
	logic fifo_on;
	logic [31:0] ctl0_cfg;
	logic [31:0] bytemask;

	////////////////////////////////////////////////////////////////////////
	// Decoded configuration
	assign widx = s_awaddr[5:2];
	assign ridx = s_araddr[5:2];
	assign ctl0_cfg = q_r.regs[`REG_CTL0 >> 2];
	assign fd_on = ctl0_cfg[`CTL0_FD_ENABLE];
	assign fifo_on = ctl0_cfg[`CTL0_RX_FIFO_ENABLE];
	assign bytemask = {{8{s_wstrb[3]}}, {8{s_wstrb[2]}},
		{8{s_wstrb[1]}}, {8{s_wstrb[0]}}};

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		q_nxt = q_r;
		q_nxt.tick = 1'b0;

		// Register bus write: offer ready, then take both channels at once
		if (q_r.bvalid && s_bready) begin
			q_nxt.bvalid = 1'b0;
		end
		if (q_r.awready) begin
			q_nxt.awready = 1'b0;
			q_nxt.wready = 1'b0;
			q_nxt.bvalid = 1'b1;
			q_nxt.bresp = `RESP_OKAY;
			if (widx == 4'h0) begin
				if (s_wstrb[0] && s_wdata[0] && q_r.st == can_host_pkg::S_IDLE) begin
					q_nxt.st = can_host_pkg::S_CHK;
					q_nxt.init_done = 1'b0;
					q_nxt.synced = 1'b0;
				end else if (s_wstrb[0] && s_wdata[1]
					&& q_r.st == can_host_pkg::S_IDLE) begin
					q_nxt.st = can_host_pkg::S_SV_DESC;
				end
			end else if (widx == 4'hD || widx == 4'hE) begin
				q_nxt.bresp = `RESP_SLVERR;
			end else begin
				q_nxt.regs[widx] = (q_r.regs[widx] & ~bytemask)
					| (s_wdata & bytemask);
			end
		end else if (s_awvalid && s_wvalid && !q_r.bvalid) begin
			q_nxt.awready = 1'b1;
			q_nxt.wready = 1'b1;
		end

		// Register bus read
		if (q_r.rvalid && s_rready) begin
			q_nxt.rvalid = 1'b0;
		end
		if (q_r.arready) begin
			q_nxt.arready = 1'b0;
			q_nxt.rvalid = 1'b1;
			q_nxt.rresp = `RESP_OKAY;
			if (ridx == 4'h0) begin
				q_nxt.rdata = {26'h000_0000, q_r.synced, q_r.init_done,
					q_r.st};
			end else begin
				q_nxt.rdata = q_r.regs[ridx];
			end
		end else if (s_arvalid && !q_r.rvalid) begin
			q_nxt.arready = 1'b1;
		end

		// Time tick for the counter source, one cycle wide
		if (q_r.regs[`REG_TICKDIV >> 2][15:0] != 16'h0000) begin
			if (q_r.tick_cnt >= q_r.regs[`REG_TICKDIV >> 2][15:0]) begin
				q_nxt.tick_cnt = 16'h0000;
				q_nxt.tick = 1'b1;
			end else begin
				q_nxt.tick_cnt = q_r.tick_cnt + 16'h0001;
			end
		end else begin
			q_nxt.tick_cnt = 16'h0000;
		end

		// Device access sequencer; a request stands until acknowledged
		unique case (q_r.st)
			can_host_pkg::S_IDLE: begin
				q_nxt.dev_req = 1'b0;
			end
			can_host_pkg::S_CHK: begin
				// Check that the device came up inactive
				if (!q_r.dev_req) begin
					q_nxt.dev_req = 1'b1;
					q_nxt.dev_write = 1'b0;
					q_nxt.dev_addr = `DEV_CTL0;
				end else if (dev_ack) begin
					q_nxt.dev_req = 1'b0;
					q_nxt.step = `STEP_STAT;
					q_nxt.st = dev_rdata[`CTL0_INACTIVE_STATE] ? can_host_pkg::S_WR
						: can_host_pkg::S_ENTER;
				end
			end
			can_host_pkg::S_ENTER: begin
				// Halt only counts with inactive enable set
				if (!q_r.dev_req) begin
					q_nxt.dev_req = 1'b1;
					q_nxt.dev_write = 1'b1;
					q_nxt.dev_addr = `DEV_CTL0;
					q_nxt.dev_wdata = ctl0_cfg | (32'h0000_0001 << `CTL0_HALT)
						| (32'h0000_0001 << `CTL0_INACTIVE_MODE_ENABLE);
				end else if (dev_ack) begin
					q_nxt.dev_req = 1'b0;
					q_nxt.st = can_host_pkg::S_CHK;
				end
			end
			can_host_pkg::S_WR: begin
				if (q_r.dev_req) begin
					if (dev_ack) begin
						q_nxt.dev_req = 1'b0;
						q_nxt.step = q_r.step + 6'h01;
						if (q_r.step == `STEP_RUN) begin
							q_nxt.st = can_host_pkg::S_SYNC;
							q_nxt.init_done = 1'b1;
						end
					end
				end else if (!fd_on && (q_r.step == `STEP_FDCTL
					|| q_r.step == `STEP_FDBT)) begin
					q_nxt.step = q_r.step + 6'h01; // FD words skipped
				end else begin
					q_nxt.dev_req = 1'b1;
					q_nxt.dev_write = 1'b1;
					unique case (q_r.step)
						`STEP_STAT: begin
							// Clear FIFO when on, and transmit flags
							q_nxt.dev_addr = `DEV_STAT;
							q_nxt.dev_wdata = `STAT_TX_FLAGS
								| (fifo_on ? `STAT_FIFO_CLR : 32'h0000_0000);
						end
						`STEP_CTL2: begin
							// Protocol variant before FD enable
							q_nxt.dev_addr = `DEV_CTL2;
							q_nxt.dev_wdata = q_r.regs[`REG_CTL2 >> 2];
						end
						`STEP_CTL0: begin
							// Memory size, FIFO, wakeup and FD bits while
							// halted
							q_nxt.dev_addr = `DEV_CTL0;
							q_nxt.dev_wdata = (ctl0_cfg
								& ~(fifo_on ? 32'h0000_0000 : `CTL0_FS_MASK))
								| (32'h0000_0001 << `CTL0_HALT)
								| (32'h0000_0001 << `CTL0_INACTIVE_MODE_ENABLE);
						end
						`STEP_BT: begin
							q_nxt.dev_addr = `DEV_BT;
							q_nxt.dev_wdata = q_r.regs[`REG_BT >> 2]
								& `BT_MASK;
						end
						`STEP_CTL1: begin
							q_nxt.dev_addr = `DEV_CTL1;
							q_nxt.dev_wdata = q_r.regs[`REG_CTL1 >> 2];
						end
						`STEP_FDCTL: begin
							q_nxt.dev_addr = `DEV_FDCTL;
							q_nxt.dev_wdata = q_r.regs[`REG_FDCTL >> 2];
						end
						`STEP_FDBT: begin
							q_nxt.dev_addr = `DEV_FDBT;
							q_nxt.dev_wdata = q_r.regs[`REG_FDBT >> 2]
								& `FDBT_MASK;
						end
						`STEP_PUB: begin
							q_nxt.dev_addr = `DEV_PUBMASK;
							q_nxt.dev_wdata = q_r.regs[`REG_PUB >> 2];
						end
						`STEP_FPUB: begin
							q_nxt.dev_addr = `DEV_FIFOPUBMASK;
							q_nxt.dev_wdata = q_r.regs[`REG_FPUB >> 2];
						end
						`STEP_INTEN: begin
							q_nxt.dev_addr = `DEV_INTEN;
							q_nxt.dev_wdata = q_r.regs[`REG_INTEN >> 2];
						end
						`STEP_RUN: begin
							// Drop halt to leave inactive mode
							q_nxt.dev_addr = `DEV_CTL0;
							q_nxt.dev_wdata = (ctl0_cfg
								& ~(fifo_on ? 32'h0000_0000 : `CTL0_FS_MASK))
								& ~(32'h0000_0001 << `CTL0_HALT);
						end
						default: begin
							// Private masks, one word per step
							q_nxt.dev_addr = `DEV_PRIVMASK
								+ {4'h0, q_r.step - `STEP_PRIV, 2'b00};
							q_nxt.dev_wdata = q_r.regs[`REG_PRIV >> 2];
						end
					endcase
				end
			end
			can_host_pkg::S_SYNC: begin
				// Poll until the device reports ready on the bus
				if (!q_r.dev_req) begin
					q_nxt.dev_req = 1'b1;
					q_nxt.dev_write = 1'b0;
					q_nxt.dev_addr = `DEV_CTL0;
				end else if (dev_ack) begin
					q_nxt.dev_req = 1'b0;
					if (!dev_rdata[`CTL0_NOT_READY]) begin
						q_nxt.synced = 1'b1;
						q_nxt.st = can_host_pkg::S_IDLE;
					end
				end
			end
			can_host_pkg::S_SV_DESC: begin
				// Descriptor first, then flag clear, then timer
				if (!q_r.dev_req) begin
					q_nxt.dev_req = 1'b1;
					q_nxt.dev_write = 1'b0;
					q_nxt.dev_addr = q_r.regs[`REG_SVADDR >> 2][11:0];
				end else if (dev_ack) begin
					q_nxt.dev_req = 1'b0;
					q_nxt.regs[`REG_DESC >> 2] = dev_rdata;
					q_nxt.st = can_host_pkg::S_SV_CLR;
				end
			end
			can_host_pkg::S_SV_CLR: begin
				if (!q_r.dev_req) begin
					q_nxt.dev_req = 1'b1;
					q_nxt.dev_write = 1'b1;
					q_nxt.dev_addr = `DEV_STAT;
					q_nxt.dev_wdata = q_r.regs[`REG_SVFLAG >> 2];
				end else if (dev_ack) begin
					q_nxt.dev_req = 1'b0;
					q_nxt.st = can_host_pkg::S_SV_TMR;
				end
			end
			can_host_pkg::S_SV_TMR: begin
				if (!q_r.dev_req) begin
					q_nxt.dev_req = 1'b1;
					q_nxt.dev_write = 1'b0;
					q_nxt.dev_addr = `DEV_TIMER;
				end else if (dev_ack) begin
					q_nxt.dev_req = 1'b0;
					q_nxt.regs[`REG_TIMER >> 2] = {16'h0000, dev_rdata[15:0]};
					q_nxt.st = can_host_pkg::S_IDLE;
				end
			end
			default: begin
				q_nxt.st = can_host_pkg::S_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	// Outputs straight from the state register
	assign s_awready = q_r.awready;
	assign s_wready = q_r.wready;
	assign s_bvalid = q_r.bvalid;
	assign s_bresp = q_r.bresp;
	assign s_arready = q_r.arready;
	assign s_rvalid = q_r.rvalid;
	assign s_rdata = q_r.rdata;
	assign s_rresp = q_r.rresp;
	assign dev_req = q_r.dev_req;
	assign dev_write = q_r.dev_write;
	assign dev_addr = q_r.dev_addr;
	assign dev_wdata = q_r.dev_wdata;
	assign external_time_tick = q_r.tick;

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_desc_done;
		q_r.st == can_host_pkg::S_SV_DESC && dev_req && dev_ack;
	endsequence
	sequence s_clear_write;
		dev_req && dev_write && dev_addr == `DEV_STAT;
	endsequence

	property p_svc_order;
		@(posedge aclk) disable iff (!aresetn)
		s_desc_done |=> ##1 s_clear_write;
	endproperty
	a_svc_order: assert property (p_svc_order)
		else $error("Flag clear did not follow descriptor read");

	property p_fifo_clear;
		@(posedge aclk) disable iff (!aresetn)
		(dev_req && q_r.st == can_host_pkg::S_WR && q_r.step == `STEP_STAT)
		|-> dev_addr == `DEV_STAT && dev_wdata[0] == fifo_on;
	endproperty
	a_fifo_clear: assert property (p_fifo_clear)
		else $error("Status clear word wrong");

	property p_halt_kept;
		@(posedge aclk) disable iff (!aresetn)
		(dev_req && dev_write && dev_addr == `DEV_CTL0
			&& q_r.st == can_host_pkg::S_WR && q_r.step != `STEP_RUN)
		|-> dev_wdata[`CTL0_HALT] && dev_wdata[`CTL0_INACTIVE_MODE_ENABLE];
	endproperty
	a_halt_kept: assert property (p_halt_kept)
		else $error("Halt dropped during configuration");

	property p_bt_mask;
		@(posedge aclk) disable iff (!aresetn)
		(dev_req && dev_addr == `DEV_BT) |-> (dev_wdata & ~`BT_MASK) == 0;
	endproperty
	a_bt_mask: assert property (p_bt_mask)
		else $error("Nominal timing word out of field range");

	property p_fdbt_mask;
		@(posedge aclk) disable iff (!aresetn)
		(dev_req && dev_addr == `DEV_FDBT) |-> fd_on
			&& (dev_wdata & ~`FDBT_MASK) == 0;
	endproperty
	a_fdbt_mask: assert property (p_fdbt_mask)
		else $error("Data timing word bad");

	property p_inten;
		@(posedge aclk) disable iff (!aresetn)
		(dev_req && dev_addr == `DEV_INTEN)
		|-> dev_write && dev_wdata == q_r.regs[`REG_INTEN >> 2];
	endproperty
	a_inten: assert property (p_inten)
		else $error("Interrupt enable word bad");

	property p_run;
		@(posedge aclk) disable iff (!aresetn)
		(dev_req && dev_ack && q_r.st == can_host_pkg::S_WR
			&& q_r.step == `STEP_RUN && !dev_wdata[`CTL0_HALT])
		|=> q_r.st == can_host_pkg::S_SYNC ##1 dev_req && !dev_write;
	endproperty
	a_run: assert property (p_run)
		else $error("Halt release not followed by readiness poll");

	property p_enter;
		@(posedge aclk) disable iff (!aresetn)
		(q_r.st == can_host_pkg::S_ENTER && dev_req)
		|-> dev_wdata[`CTL0_HALT] && dev_wdata[`CTL0_INACTIVE_MODE_ENABLE];
	endproperty
	a_enter: assert property (p_enter)
		else $error("Inactive entry lacks enable");

	property p_tick;
		@(posedge aclk) disable iff (!aresetn)
		external_time_tick |=> !external_time_tick;
	endproperty
	a_tick: assert property (p_tick)
		else $error("Time tick wider than one cycle");

endmodule
`default_nettype wire

//--- can_host_map.svh
// Register offsets, field positions and step numbers for the CAN bring-up host
`ifndef CAN_HOST_MAP_SVH
`define CAN_HOST_MAP_SVH

// Device register offsets
`define DEV_CTL0 12'h000
`define DEV_CTL1 12'h004
`define DEV_TIMER 12'h008
`define DEV_CTL2 12'h00C
`define DEV_STAT 12'h010
`define DEV_INTEN 12'h014
`define DEV_BT 12'h018
`define DEV_FDCTL 12'h01C
`define DEV_FDBT 12'h020
`define DEV_PUBMASK 12'h024
`define DEV_FIFOPUBMASK 12'h028
`define DEV_PRIVMASK 12'h100

// Control register 0 bit positions and field mask, status clear words
`define CTL0_INACTIVE_MODE_ENABLE 30
`define CTL0_RX_FIFO_ENABLE 29
`define CTL0_HALT 28
`define CTL0_NOT_READY 27
`define CTL0_INACTIVE_STATE 24
`define CTL0_RX_FIFO_DMA_ENABLE 15
`define CTL0_FD_ENABLE 11
`define CTL0_FS_MASK 32'h0000_0300
`define STAT_FIFO_CLR 32'h0000_0001
`define STAT_TX_FLAGS 32'hFFFF_FFFE

// Field masks for the timing words
`define BT_MASK 32'h7FFF_FFFF
`define FDBT_MASK 32'h0FFF_3FFF

// Own register map, byte offsets
`define REG_CMD 6'h00
`define REG_CTL0 6'h04
`define REG_CTL1 6'h08
`define REG_CTL2 6'h0C
`define REG_BT 6'h10
`define REG_FDCTL 6'h14
`define REG_FDBT 6'h18
`define REG_INTEN 6'h1C
`define REG_PUB 6'h20
`define REG_FPUB 6'h24
`define REG_PRIV 6'h28
`define REG_SVADDR 6'h2C
`define REG_SVFLAG 6'h30
`define REG_DESC 6'h34
`define REG_TIMER 6'h38
`define REG_TICKDIV 6'h3C

// Bring-up steps
`define STEP_STAT 6'h00
`define STEP_CTL2 6'h01
`define STEP_CTL0 6'h02
`define STEP_BT 6'h03
`define STEP_CTL1 6'h04
`define STEP_FDCTL 6'h05
`define STEP_FDBT 6'h06
`define STEP_PUB 6'h07
`define STEP_FPUB 6'h08
`define STEP_PRIV 6'h09
`define STEP_PRIV_LAST 6'h28
`define STEP_INTEN 6'h29
`define STEP_RUN 6'h2A

// Bus answer codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- can_host_pkg.sv
// Types for the CAN bring-up host
package can_host_pkg;

	typedef enum logic [3:0] {
		S_IDLE, S_CHK, S_ENTER, S_WR, S_SYNC, S_SV_DESC, S_SV_CLR, S_SV_TMR
	} state_t;

	typedef struct packed {
		state_t st;
		logic [5:0] step;
		logic init_done;
		logic synced;
		logic [15:0][31:0] regs;
		logic dev_req;
		logic dev_write;
		logic [11:0] dev_addr;
		logic [31:0] dev_wdata;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [15:0] tick_cnt;
		logic tick;
	} host_t;

endpackage

//--- can_dev_model.sv
// Behavioural model of the CAN controller seen through its register port
`timescale 1ns/1ps
`default_nettype none

module can_dev_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] lat,
	input wire logic dev_req,
	input wire logic dev_write,
	input wire logic [11:0] dev_addr,
	input wire logic [31:0] dev_wdata,
	output logic dev_ack,
	output logic [31:0] dev_rdata
);
	logic [31:0] ctl0_r, rd_r, c;
	logic [31:0] mem_r [0:127];
	logic [15:0] timer_r;
	logic [1:0] sync_r;
	logic [3:0] wait_r;
	logic [44:0] log_q[$];

	////////////////////////////////////////////////////////////////////////
	// Data outside the acknowledge cycle never shows the last word
	assign dev_rdata = dev_ack ? rd_r : ~rd_r;

	////////////////////////////////////////////////////////////////////////
	// Register access with a programmable answer delay, every access logged
	always @(posedge aclk) begin
		dev_ack <= 1'b0;
		if (!aresetn) begin
			ctl0_r <= 32'h5900_000F;
			timer_r <= 16'h0000;
			sync_r <= 2'd0;
			wait_r <= 4'h0;
			rd_r <= 32'h0000_0000;
		end else begin
			if (!ctl0_r[24] && !ctl0_r[20]) begin
				timer_r <= timer_r + 16'h0001;
			end
			if (dev_req && !dev_ack && wait_r < lat) begin
				wait_r <= wait_r + 4'h1;
			end else if (dev_req && !dev_ack) begin
				wait_r <= 4'h0;
				dev_ack <= 1'b1;
				if (dev_write) begin
					log_q.push_back({1'b1, dev_addr, dev_wdata});
					c = dev_wdata;
					if (dev_addr != 12'h000) begin
						mem_r[dev_addr[8:2]] <= c;
					end else if (c[28] && c[30]) begin
						ctl0_r <= c | 32'h0900_0000;
					end else if (!c[28]) begin
						ctl0_r <= {c[31:28], ctl0_r[27], c[26:25], 1'b0, c[23:0]};
						sync_r <= 2'd2;
					end else begin
						ctl0_r <= {c[31:28], ctl0_r[27], c[26:25], ctl0_r[24], c[23:0]};
					end
				end else begin
					if (dev_addr == 12'h000) begin
						c = ctl0_r;
					end else if (dev_addr == 12'h008) begin
						c = {16'h0000, timer_r};
					end else begin
						c = mem_r[dev_addr[8:2]];
					end
					rd_r <= c;
					log_q.push_back({1'b0, dev_addr, c});
					if (dev_addr == 12'h000 && sync_r != 2'd0) begin
						sync_r <= sync_r - 2'd1;
						if (sync_r == 2'd1) begin
							ctl0_r[27] <= 1'b0;
						end
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- can_timestamp_irq_config_tb.sv
// Self-checking bench for the CAN bring-up host and its flag service
`timescale 1ns/1ps
`default_nettype none
`include "can_host_map.svh"

module can_timestamp_irq_config_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [5:0] s_awaddr = 6'h00;
	logic [5:0] s_araddr = 6'h00;
	logic s_awvalid = 1'b0;
	logic s_wvalid = 1'b0;
	logic s_bready = 1'b0;
	logic s_arvalid = 1'b0;
	logic s_rready = 1'b0;
	logic [31:0] s_wdata = 32'h0000_0000;
	logic [3:0] s_wstrb = 4'h0;
	logic [3:0] lat = 4'h0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic dev_req, dev_write, dev_ack, external_time_tick;
	logic [1:0] s_bresp, s_rresp;
	logic [31:0] s_rdata, dev_wdata, dev_rdata;
	logic [11:0] dev_addr;
	int err_count = 0;
	int compares = 0;
	logic [11:0] ea[$];
	logic [31:0] ed[$];
	logic [44:0] lq[$];

	////////////////////////////////////////////////////////////////////////
	// Host under test and device model
	can_host_ctrl dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready), .dev_req(dev_req),
		.dev_write(dev_write), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
		.dev_ack(dev_ack), .dev_rdata(dev_rdata),
		.external_time_tick(external_time_tick));
	can_dev_model dev_model_u (.aclk(aclk), .aresetn(aresetn), .lat(lat),
		.dev_req(dev_req), .dev_write(dev_write), .dev_addr(dev_addr),
		.dev_wdata(dev_wdata), .dev_ack(dev_ack), .dev_rdata(dev_rdata));

	// 200 MHz clock
	always #2.5 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////
	// Compare, count and report
	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Bus write, address and data offered together
	task automatic axi_wr(input logic [5:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] exp);
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_wstrb <= s;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_awready === 1'b1) s_awvalid <= 1'b0;
			if (s_wready === 1'b1) s_wvalid <= 1'b0;
		end while (s_bvalid !== 1'b1);
		chk("write response", 32'(s_bresp), 32'(exp));
		s_bready <= 1'b0;
	endtask

	// Bus read
	task automatic axi_rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_arready === 1'b1) s_arvalid <= 1'b0;
		end while (s_rvalid !== 1'b1);
		d = s_rdata;
		chk("read response", 32'(s_rresp), 32'h0000_0000);
		s_rready <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Bring-up run; the second run finds the device active and re-halts it
	task automatic run_init(input logic [31:0] cfg, input bit enter);
		logic [31:0] c0, d;
		int k, i, n;
		ea.delete();
		ed.delete();
		dev_model_u.log_q.delete();
		c0 = cfg | 32'h5000_0000;
		if (!cfg[29]) c0 = c0 & 32'hFFFF_FCFF;
		d = enter ? 32'h7FFF_FF12 : 32'h7FFF_FFFF;
		ea = '{12'h010, 12'h00C, 12'h000, 12'h018, 12'h004};
		ed = '{32'hFFFF_FFFE | 32'(cfg[29]), 32'h2222_0002, c0, d,
			32'h1111_0001};
		if (cfg[11]) begin
			ea.push_back(12'h01C);
			ed.push_back(32'h0000_1F83);
			ea.push_back(12'h020);
			ed.push_back(32'h0FFF_3FFF);
		end
		ea.push_back(12'h024);
		ed.push_back(32'hA5A5_0001);
		ea.push_back(12'h028);
		ed.push_back(32'h5A5A_0002);
		for (i = 0; i < 32; i++) begin
			ea.push_back(12'h100 + 12'(4 * i));
			ed.push_back(32'h0F0F_0003);
		end
		ea.push_back(12'h014);
		ed.push_back(32'h0000_00E0);
		ea.push_back(12'h000);
		axi_wr(`REG_CTL0, cfg, 4'hF, `RESP_OKAY);
		if (enter) axi_wr(`REG_BT, 32'h0000_0012, 4'h1, `RESP_OKAY);
		axi_wr(`REG_CMD, 32'h0000_0001, 4'hF, `RESP_OKAY);
		n = 0;
		do begin
			axi_rd(`REG_CMD, d);
			n++;
		end while (d[5] !== 1'b1 && n < 200);
		chk("synced", 32'(d[5]), 32'h1);
		lq = dev_model_u.log_q;
		k = enter ? 3 : 1;
		chk("log length", 32'(lq.size() > k + ea.size()), 32'h1);
		chk("first read", 32'(lq[0][44:32]), 32'h0000_0000);
		if (enter) begin
			chk("halt write", 32'(lq[1][44:32]), 32'h0000_1000);
			chk("halt bits", lq[1][31:0] & 32'h5000_0000, 32'h5000_0000);
			chk("reread", 32'(lq[2][44:32]), 32'h0000_0000);
		end
		for (i = 0; i < ea.size(); i++) begin
			chk("init address", 32'(lq[k+i][44:32]), 32'h1000 | 32'(ea[i]));
			if (i < ea.size() - 1) chk("init data", lq[k+i][31:0], ed[i]);
		end
		chk("halt cleared", 32'(lq[k+ea.size()-1][28]), 32'h0);
		chk("ready poll", 32'(lq[$][44:32]), 32'h0000_0000);
		chk("ready bit", 32'(lq[$][27]), 32'h0);
		$display("init test done, enter %0d", enter);
	endtask

	// Flag service against a prompt or slow device
	task automatic service(input logic [3:0] l);
		logic [31:0] d;
		int n;
		lat <= l;
		dev_model_u.log_q.delete();
		axi_wr(`REG_CMD, 32'h0000_0002, 4'hF, `RESP_OKAY);
		n = 0;
		while (dev_model_u.log_q.size() < 3 && n < 500) begin
			@(posedge aclk);
			n++;
		end
		repeat (4) @(posedge aclk);
		lq = dev_model_u.log_q;
		chk("service count", 32'(lq.size()), 32'h3);
		chk("descriptor read", 32'(lq[0][44:32]), 32'h0000_0024);
		chk("flag clear", 32'(lq[1][44:32]), 32'h0000_1010);
		chk("flag value", lq[1][31:0], 32'h0000_0020);
		chk("timer read", 32'(lq[2][44:32]), 32'h0000_0008);
		axi_rd(`REG_DESC, d);
		chk("descriptor", d, 32'hA5A5_0001);
		axi_rd(`REG_TIMER, d);
		chk("timer", d, 32'(lq[2][15:0]));
		axi_wr(`REG_TIMER, 32'hFFFF_FFFF, 4'hF, `RESP_SLVERR);
		axi_wr(`REG_DESC, 32'h0000_0000, 4'hF, `RESP_SLVERR);
		axi_rd(`REG_DESC, d);
		chk("descriptor kept", d, 32'hA5A5_0001);
		$display("service test done, latency %0d", l);
	endtask

	// External time tick spacing and switch-off
	task automatic test_tick();
		int n, gap;
		axi_wr(`REG_TICKDIV, 32'h0000_0003, 4'hF, `RESP_OKAY);
		n = 0;
		while (external_time_tick !== 1'b1 && n < 50) begin
			@(posedge aclk);
			n++;
		end
		gap = 0;
		do begin
			@(posedge aclk);
			gap++;
		end while (external_time_tick !== 1'b1 && gap < 50);
		chk("tick spacing", 32'(gap), 32'h4);
		axi_wr(`REG_TICKDIV, 32'h0000_0000, 4'hF, `RESP_OKAY);
		repeat (5) @(posedge aclk);
		n = 0;
		repeat (40) begin
			@(posedge aclk);
			if (external_time_tick === 1'b1) n++;
		end
		chk("tick off", 32'(n), 32'h0);
		$display("tick test done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [5:0] sa [11] = '{`REG_CTL1, `REG_CTL2, `REG_BT, `REG_FDCTL,
			`REG_FDBT, `REG_INTEN, `REG_PUB, `REG_FPUB, `REG_PRIV,
			`REG_SVADDR, `REG_SVFLAG};
		logic [31:0] sd [11] = '{32'h1111_0001, 32'h2222_0002, 32'hFFFF_FFFF,
			32'h0000_1F83, 32'hFFFF_FFFF, 32'h0000_00E0, 32'hA5A5_0001,
			32'h5A5A_0002, 32'h0F0F_0003, 32'h0000_0024, 32'h0000_0020};
		logic [31:0] d;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("idle request", 32'(dev_req), 32'h0);
		axi_rd(`REG_CMD, d);
		chk("command after reset", d, 32'h0000_0000);
		for (int i = 0; i < 11; i++) begin
			axi_wr(sa[i], sd[i], 4'hF, `RESP_OKAY);
		end
		$display("reset test done");
		run_init(32'h2000_0B0F, 1'b0);
		run_init(32'h0000_030F, 1'b1);
		service(4'h0);
		service(4'h6);
		test_tick();
		wrap_up();
	end

	// Watchdog
	initial begin
		#200000;
		err_count++;
		$display("watchdog expired");
		wrap_up();
	end
endmodule
`default_nettype wire
